// ==== rtl/wsccr_pkg.sv ====
// Constants and types for the window stride and colour conversion register bank.
// Assumes a 32-bit AHB-Lite slave port with 16-bit byte addresses.
`default_nettype none
package wsccr_pkg;
   localparam int unsigned WSCCR_AW = 16;
   localparam int unsigned WSCCR_DW = 32;
   localparam int unsigned WSCCR_RW = 16;
   localparam int unsigned WSCCR_STRIDE_W = 14;
   localparam int unsigned WSCCR_COEF_W = 11;
   localparam int unsigned WSCCR_COEF_N = 9;
   localparam int unsigned WSCCR_LADDR_W = 26;
   localparam int unsigned WSCCR_WIN_N = 3;
   // Register indices; byte address is the index times four
   localparam logic [15:0] WSCCR_IDX_MAIN_FRONT = 16'h086a;
   localparam logic [15:0] WSCCR_IDX_OV1_FRONT = 16'h086c;
   localparam logic [15:0] WSCCR_IDX_OV2_FRONT = 16'h086e;
   localparam logic [15:0] WSCCR_IDX_BACK = 16'h0870;
   localparam logic [15:0] WSCCR_IDX_CTL = 16'h0880;
   localparam logic [15:0] WSCCR_IDX_STAT = 16'h0882;
   localparam logic [15:0] WSCCR_IDX_COEF0 = 16'h0892;
   localparam logic [15:0] WSCCR_IDX_COEF_STEP = 16'h0002;
   // Field positions
   localparam int unsigned WSCCR_CTL_EN_BIT = 0;
   localparam int unsigned WSCCR_CTL_SEL_LSB = 3;
   localparam int unsigned WSCCR_CTL_SEL_MSB = 4;
   localparam int unsigned WSCCR_CTL_UV_BIT = 7;
   localparam int unsigned WSCCR_STAT_VND_BIT = 0;
   localparam int unsigned WSCCR_STAT_VIOL_BIT = 1;
   localparam logic [15:0] WSCCR_CTL_MASK = 16'h0099;
   // Reset values
   localparam logic [13:0] WSCCR_STRIDE_RST = 14'h0000;
   localparam logic [15:0] WSCCR_CTL_RST = 16'h0000;
   localparam logic [10:0] WSCCR_COEF_RST = 11'h000;
   localparam logic [25:0] WSCCR_LADDR_RST = 26'h0000000;

   typedef enum logic [1:0] {
      WSCCR_SEL_ALL,
      WSCCR_SEL_OV1,
      WSCCR_SEL_OV2,
      WSCCR_SEL_NONE
   } wsccr_sel_e;

   typedef enum logic [2:0] {
      WSCCR_REG_NONE,
      WSCCR_REG_MAIN,
      WSCCR_REG_OV1,
      WSCCR_REG_OV2,
      WSCCR_REG_BACK,
      WSCCR_REG_CTL,
      WSCCR_REG_STAT,
      WSCCR_REG_COEF
   } wsccr_reg_e;

   typedef enum logic [1:0] {
      WSCCR_ST_IDLE,
      WSCCR_ST_WRITE,
      WSCCR_ST_RDWAIT,
      WSCCR_ST_RDDONE
   } wsccr_bus_e;
endpackage
`default_nettype wire

// ==== rtl/wsccr_line_step.sv ====
// Line start address stepper for one display window.
// Assumes frame start and line advance strobes from fetch logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wsccr_line_step (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   input wire logic i_frame_start,
   input wire logic i_line_next,
   input wire logic [wsccr_pkg::WSCCR_LADDR_W-1:0] i_base,
   input wire logic [wsccr_pkg::WSCCR_STRIDE_W-1:0] i_stride,
   output logic [wsccr_pkg::WSCCR_LADDR_W-1:0] o_line_addr
);
   import wsccr_pkg::*;

   logic [WSCCR_LADDR_W-1:0] line_reg;
   logic [WSCCR_LADDR_W-1:0] line_next;

   always_comb begin
      line_next = line_reg;
      if (i_frame_start) begin
         line_next = i_base;
      end else if (i_line_next) begin
         // Step by the byte stride per line
         line_next = line_reg + {{(WSCCR_LADDR_W-WSCCR_STRIDE_W){1'b0}}, i_stride};
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         line_reg <= WSCCR_LADDR_RST;
      end else if (i_clk_en) begin
         line_reg <= line_next;
      end
   end

   assign o_line_addr = line_reg;
endmodule
`default_nettype wire

// ==== rtl/wsccr_regs.sv ====
// Stride and colour conversion register bank with an AHB-Lite slave port.
// Assumes single word transfers, display timing and fetch strobes on i_clock.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module wsccr_regs (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   input wire logic i_hsel,
   input wire logic [wsccr_pkg::WSCCR_AW-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [wsccr_pkg::WSCCR_DW-1:0] i_hwdata,
   input wire logic i_hready,
   output logic [wsccr_pkg::WSCCR_DW-1:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_vnd,
   input wire logic [wsccr_pkg::WSCCR_WIN_N-1:0] i_use_back,
   input wire logic [wsccr_pkg::WSCCR_WIN_N-1:0] i_frame_start,
   input wire logic [wsccr_pkg::WSCCR_WIN_N-1:0] i_line_next,
   input wire logic [wsccr_pkg::WSCCR_LADDR_W-1:0] i_main_base,
   input wire logic [wsccr_pkg::WSCCR_LADDR_W-1:0] i_ov1_base,
   input wire logic [wsccr_pkg::WSCCR_LADDR_W-1:0] i_ov2_base,
   output logic [wsccr_pkg::WSCCR_LADDR_W-1:0] o_main_line_addr,
   output logic [wsccr_pkg::WSCCR_LADDR_W-1:0] o_ov1_line_addr,
   output logic [wsccr_pkg::WSCCR_LADDR_W-1:0] o_ov2_line_addr,
   output logic [wsccr_pkg::WSCCR_STRIDE_W-1:0] o_main_stride,
   output logic [wsccr_pkg::WSCCR_STRIDE_W-1:0] o_ov1_stride,
   output logic [wsccr_pkg::WSCCR_STRIDE_W-1:0] o_ov2_stride,
   output logic [wsccr_pkg::WSCCR_STRIDE_W-1:0] o_back_stride,
   output logic o_conv_main,
   output logic o_conv_ov1,
   output logic o_conv_ov2,
   output logic o_uv_offset_en,
   output logic [wsccr_pkg::WSCCR_COEF_N-1:0][wsccr_pkg::WSCCR_COEF_W-1:0] o_coef
);
   import wsccr_pkg::*;

   // Register index decode, shared by address capture and coefficient select
   function automatic wsccr_reg_e reg_decode(input logic [WSCCR_AW-1:0] addr);
      logic [15:0] idx;
      logic [15:0] off;
      idx = {2'b00, addr[WSCCR_AW-1:2]};
      off = idx - WSCCR_IDX_COEF0;
      reg_decode = WSCCR_REG_NONE;
      if (addr[1:0] == 2'b00) begin
         case (idx)
            WSCCR_IDX_MAIN_FRONT: reg_decode = WSCCR_REG_MAIN;
            WSCCR_IDX_OV1_FRONT: reg_decode = WSCCR_REG_OV1;
            WSCCR_IDX_OV2_FRONT: reg_decode = WSCCR_REG_OV2;
            WSCCR_IDX_BACK: reg_decode = WSCCR_REG_BACK;
            WSCCR_IDX_CTL: reg_decode = WSCCR_REG_CTL;
            WSCCR_IDX_STAT: reg_decode = WSCCR_REG_STAT;
            default: begin
               if (idx >= WSCCR_IDX_COEF0 && off[0] == 1'b0
                   && off[15:1] < 15'(WSCCR_COEF_N)) begin
                  reg_decode = WSCCR_REG_COEF;
               end
            end
         endcase
      end
   endfunction

   function automatic logic [3:0] coef_num(input logic [WSCCR_AW-1:0] addr);
      logic [15:0] off;
      off = {2'b00, addr[WSCCR_AW-1:2]} - WSCCR_IDX_COEF0;
      coef_num = off[4:1];
   endfunction

   // Bus slave state
   wsccr_bus_e state_reg;
   wsccr_bus_e state_next;
   wsccr_reg_e sel_reg;
   wsccr_reg_e sel_next;
   logic [3:0] cnum_reg;
   logic [3:0] cnum_next;
   logic [WSCCR_DW-1:0] hrdata_reg;
   logic [WSCCR_DW-1:0] hrdata_next;
   logic hready_reg;
   logic hready_next;
   logic accept;
   logic wr_now;
   logic [WSCCR_RW-1:0] rd_value;

   // Register state
   logic [WSCCR_STRIDE_W-1:0] main_reg;
   logic [WSCCR_STRIDE_W-1:0] main_next;
   logic [WSCCR_STRIDE_W-1:0] ov1_reg;
   logic [WSCCR_STRIDE_W-1:0] ov1_next;
   logic [WSCCR_STRIDE_W-1:0] ov2_reg;
   logic [WSCCR_STRIDE_W-1:0] ov2_next;
   logic [WSCCR_STRIDE_W-1:0] back_reg;
   logic [WSCCR_STRIDE_W-1:0] back_next;
   logic [WSCCR_RW-1:0] ctl_reg;
   logic [WSCCR_RW-1:0] ctl_next;
   logic viol_reg;
   logic viol_next;
   logic [WSCCR_COEF_N-1:0][WSCCR_COEF_W-1:0] coef_reg;
   logic conv_main_reg;
   logic conv_ov1_reg;
   logic conv_ov2_reg;
   logic conv_main_next;
   logic conv_ov1_next;
   logic conv_ov2_next;
   wsccr_sel_e win_sel;

   assign accept = i_hsel & i_htrans[1] & i_hready;
   assign wr_now = (state_reg == WSCCR_ST_WRITE);

   always_comb begin
      state_next = state_reg;
      sel_next = sel_reg;
      cnum_next = cnum_reg;
      hrdata_next = hrdata_reg;
      case (state_reg)
         WSCCR_ST_RDWAIT: begin
            // Read data loaded after any earlier write has landed
            hrdata_next = {{(WSCCR_DW-WSCCR_RW){1'b0}}, rd_value};
            state_next = WSCCR_ST_RDDONE;
         end
         WSCCR_ST_IDLE, WSCCR_ST_WRITE, WSCCR_ST_RDDONE: begin
            if (accept) begin
               sel_next = reg_decode(i_haddr);
               cnum_next = coef_num(i_haddr);
               state_next = i_hwrite ? WSCCR_ST_WRITE : WSCCR_ST_RDWAIT;
            end else begin
               state_next = WSCCR_ST_IDLE;
            end
         end
         default: state_next = WSCCR_ST_IDLE;
      endcase
      hready_next = (state_next != WSCCR_ST_RDWAIT);
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= WSCCR_ST_IDLE;
         sel_reg <= WSCCR_REG_NONE;
         cnum_reg <= 4'h0;
         hrdata_reg <= 32'h00000000;
         hready_reg <= 1'b1;
      end else if (i_clk_en) begin
         state_reg <= state_next;
         sel_reg <= sel_next;
         cnum_reg <= cnum_next;
         hrdata_reg <= hrdata_next;
         hready_reg <= hready_next;
      end
   end

   // Read mux; unused bits are held at zero by storage width and mask
   always_comb begin
      rd_value = 16'h0000;
      case (sel_reg)
         WSCCR_REG_MAIN: rd_value = {2'b00, main_reg};
         WSCCR_REG_OV1: rd_value = {2'b00, ov1_reg};
         WSCCR_REG_OV2: rd_value = {2'b00, ov2_reg};
         WSCCR_REG_BACK: rd_value = {2'b00, back_reg};
         WSCCR_REG_CTL: rd_value = ctl_reg & WSCCR_CTL_MASK;
         WSCCR_REG_STAT: begin
            rd_value[WSCCR_STAT_VND_BIT] = i_vnd;
            rd_value[WSCCR_STAT_VIOL_BIT] = viol_reg;
         end
         WSCCR_REG_COEF: begin
            if (cnum_reg < 4'(WSCCR_COEF_N)) begin
               rd_value = {5'h00, coef_reg[cnum_reg]};
            end
         end
         default: rd_value = 16'h0000;
      endcase
   end

   always_comb begin
      main_next = main_reg;
      ov1_next = ov1_reg;
      ov2_next = ov2_reg;
      back_next = back_reg;
      ctl_next = ctl_reg;
      viol_next = viol_reg;
      if (wr_now) begin
         case (sel_reg)
            WSCCR_REG_MAIN: main_next = i_hwdata[WSCCR_STRIDE_W-1:0];
            WSCCR_REG_OV1: begin
               ov1_next = i_hwdata[WSCCR_STRIDE_W-1:0];
            end
            WSCCR_REG_OV2: ov2_next = i_hwdata[WSCCR_STRIDE_W-1:0];
            WSCCR_REG_BACK: back_next = i_hwdata[WSCCR_STRIDE_W-1:0];
            WSCCR_REG_CTL: ctl_next = i_hwdata[WSCCR_RW-1:0] & WSCCR_CTL_MASK;
            WSCCR_REG_STAT: begin
               if (i_hwdata[WSCCR_STAT_VIOL_BIT]) begin
                  viol_next = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Flag an overlay one stride write made during active display; set wins over clear
      if (wr_now && sel_reg == WSCCR_REG_OV1 && !i_vnd) begin
         viol_next = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         main_reg <= WSCCR_STRIDE_RST;
         ov1_reg <= WSCCR_STRIDE_RST;
         ov2_reg <= WSCCR_STRIDE_RST;
         back_reg <= WSCCR_STRIDE_RST;
         ctl_reg <= WSCCR_CTL_RST;
         viol_reg <= 1'b0;
      end else if (i_clk_en) begin
         main_reg <= main_next;
         ov1_reg <= ov1_next;
         ov2_reg <= ov2_next;
         back_reg <= back_next;
         ctl_reg <= ctl_next;
         viol_reg <= viol_next;
      end
   end

   // Coefficient storage, fixed point s.2.8 passed on unchanged
   genvar gi;
   generate
      for (gi = 0; gi < WSCCR_COEF_N; gi = gi + 1) begin : g_coef
         logic [WSCCR_COEF_W-1:0] cf_next;
         always_comb begin
            cf_next = coef_reg[gi];
            if (wr_now && sel_reg == WSCCR_REG_COEF && cnum_reg == 4'(gi)) begin
               cf_next = i_hwdata[WSCCR_COEF_W-1:0];
            end
         end
         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               coef_reg[gi] <= WSCCR_COEF_RST;
            end else if (i_clk_en) begin
               coef_reg[gi] <= cf_next;
            end
         end
      end
   endgenerate

   // Per-window conversion gating, registered from the next control value
   always_comb begin
      win_sel = wsccr_sel_e'(ctl_next[WSCCR_CTL_SEL_MSB:WSCCR_CTL_SEL_LSB]);
      conv_main_next = 1'b0;
      conv_ov1_next = 1'b0;
      conv_ov2_next = 1'b0;
      if (ctl_next[WSCCR_CTL_EN_BIT]) begin
         case (win_sel)
            WSCCR_SEL_ALL: begin
               conv_main_next = 1'b1;
               conv_ov1_next = 1'b1;
               conv_ov2_next = 1'b1;
            end
            WSCCR_SEL_OV1: conv_ov1_next = 1'b1;
            WSCCR_SEL_OV2: conv_ov2_next = 1'b1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         conv_main_reg <= 1'b0;
         conv_ov1_reg <= 1'b0;
         conv_ov2_reg <= 1'b0;
      end else if (i_clk_en) begin
         conv_main_reg <= conv_main_next;
         conv_ov1_reg <= conv_ov1_next;
         conv_ov2_reg <= conv_ov2_next;
      end
   end

   // Line address steppers; back buffer shares one stride
   logic [WSCCR_WIN_N-1:0][WSCCR_LADDR_W-1:0] base_w;
   logic [WSCCR_WIN_N-1:0][WSCCR_STRIDE_W-1:0] front_w;
   logic [WSCCR_WIN_N-1:0][WSCCR_LADDR_W-1:0] laddr_w;
   assign base_w[0] = i_main_base;
   assign base_w[1] = i_ov1_base;
   assign base_w[2] = i_ov2_base;
   assign front_w[0] = main_reg;
   assign front_w[1] = ov1_reg;
   assign front_w[2] = ov2_reg;

   generate
      for (gi = 0; gi < WSCCR_WIN_N; gi = gi + 1) begin : g_win
         wsccr_line_step u_step (
            .i_clock(i_clock),
            .i_nrst(i_nrst),
            .i_clk_en(i_clk_en),
            .i_frame_start(i_frame_start[gi]),
            .i_line_next(i_line_next[gi]),
            .i_base(base_w[gi]),
            .i_stride(i_use_back[gi] ? back_reg : front_w[gi]),
            .o_line_addr(laddr_w[gi])
         );
      end
   endgenerate

   assign o_hrdata = hrdata_reg;
   assign o_hreadyout = hready_reg;
   assign o_hresp = 1'b0;
   assign o_main_line_addr = laddr_w[0];
   assign o_ov1_line_addr = laddr_w[1];
   assign o_ov2_line_addr = laddr_w[2];
   assign o_main_stride = main_reg;
   assign o_ov1_stride = ov1_reg;
   assign o_ov2_stride = ov2_reg;
   assign o_back_stride = back_reg;
   assign o_conv_main = conv_main_reg;
   assign o_conv_ov1 = conv_ov1_reg;
   assign o_conv_ov2 = conv_ov2_reg;
   assign o_uv_offset_en = ctl_reg[WSCCR_CTL_UV_BIT];
   assign o_coef = coef_reg;
endmodule
`default_nettype wire

// ==== dv/wsccr_regs_monitor.sv ====
// Port assertions for the window stride and colour conversion bank.
// Assumes one clock domain; bound onto every wsccr_regs.
`timescale 1ns/1ps
`default_nettype none
module wsccr_regs_monitor
   import wsccr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   input wire logic i_hsel,
   input wire logic [WSCCR_AW-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [WSCCR_DW-1:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [WSCCR_DW-1:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic [WSCCR_WIN_N-1:0] i_use_back,
   input wire logic [WSCCR_WIN_N-1:0] i_frame_start,
   input wire logic [WSCCR_WIN_N-1:0] i_line_next,
   input wire logic [WSCCR_LADDR_W-1:0] o_main_line_addr,
   input wire logic [WSCCR_LADDR_W-1:0] o_ov1_line_addr,
   input wire logic [WSCCR_LADDR_W-1:0] o_ov2_line_addr,
   input wire logic [WSCCR_STRIDE_W-1:0] o_main_stride,
   input wire logic [WSCCR_STRIDE_W-1:0] o_ov1_stride,
   input wire logic [WSCCR_STRIDE_W-1:0] o_ov2_stride,
   input wire logic [WSCCR_STRIDE_W-1:0] o_back_stride,
   input wire logic o_conv_main,
   input wire logic o_conv_ov1,
   input wire logic o_conv_ov2,
   input wire logic [WSCCR_COEF_N-1:0][WSCCR_COEF_W-1:0] o_coef
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   // Write address taken, then its data phase
   sequence s_wr(logic [15:0] a);
      i_hsel && i_htrans[1] && i_hready && i_clk_en && i_hwrite && i_haddr == a ##1 i_clk_en;
   endsequence

   a_main_line_step: assert property (
      i_clk_en && i_line_next[0] && !i_frame_start[0] && !i_use_back[0]
      |=> o_main_line_addr == $past(o_main_line_addr) + 26'($past(o_main_stride)))
      else $error("main line step wrong");
   a_ov2_line_step: assert property (
      i_clk_en && i_line_next[2] && !i_frame_start[2] && !i_use_back[2]
      |=> o_ov2_line_addr == $past(o_ov2_line_addr) + 26'($past(o_ov2_stride)))
      else $error("ov2 line step wrong");
   a_back_line_step: assert property (
      i_clk_en && i_line_next[1] && !i_frame_start[1] && i_use_back[1]
      |=> o_ov1_line_addr == $past(o_ov1_line_addr) + 26'($past(o_back_stride)))
      else $error("back line step wrong");
   a_ov1_stride_wr: assert property (
      s_wr(16'h21b0) |=> o_ov1_stride == $past(i_hwdata[13:0]))
      else $error("ov1 stride write lost");
   a_coef_zero_wr: assert property (
      s_wr(16'h2248) |=> o_coef[0] == $past(i_hwdata[10:0]))
      else $error("coef write lost");
   a_conv_all_sel: assert property (
      o_conv_main |-> o_conv_ov1 && o_conv_ov2)
      else $error("main converted alone");
   a_conv_off_wr: assert property (
      s_wr(16'h2200) ##0 !i_hwdata[0] |=> !(o_conv_main || o_conv_ov1 || o_conv_ov2))
      else $error("conversion on while disabled");
   a_upper_zero: assert property (
      o_hreadyout |-> o_hrdata[31:16] == 16'h0000)
      else $error("unused read bits set");

   c_read_wait: cover property (i_hsel && i_htrans[1] && !i_hwrite ##1 !o_hreadyout);
   c_frame_line: cover property (i_frame_start[0] && i_line_next[0]);
   c_ov2_only: cover property (o_conv_ov2 && !o_conv_ov1);
endmodule

bind wsccr_regs wsccr_regs_monitor u_mon (
   .i_clock, .i_nrst, .i_clk_en, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
   .i_hready, .o_hrdata, .o_hreadyout, .i_use_back, .i_frame_start, .i_line_next,
   .o_main_line_addr, .o_ov1_line_addr, .o_ov2_line_addr, .o_main_stride, .o_ov1_stride,
   .o_ov2_stride, .o_back_stride, .o_conv_main, .o_conv_ov1, .o_conv_ov2, .o_coef
);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the window stride and colour conversion bank.
// Assumes the bank is the only AHB-Lite slave; its hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
   import wsccr_pkg::*;
   logic i_clock = 1'h0, i_nrst = 1'h0, i_hsel = 1'h0, i_hwrite = 1'h0;
   logic i_clk_en = 1'h1;
   logic i_vnd = 1'h1;
   logic [15:0] i_haddr = 16'h0;
   logic [1:0] i_htrans = 2'h0;
   logic [31:0] i_hwdata = 32'h0, o_hrdata, rd_s;
   logic [2:0] i_use_back = 3'h0, i_frame_start = 3'h0, i_line_next = 3'h0;
   logic [25:0] i_main_base = 26'h0, i_ov1_base = 26'h0, i_ov2_base = 26'h0;
   logic [25:0] o_main_line_addr, o_ov1_line_addr, o_ov2_line_addr;
   logic [13:0] o_main_stride, o_ov1_stride, o_ov2_stride, o_back_stride;
   logic o_hreadyout, o_hresp, o_conv_main, o_conv_ov1, o_conv_ov2, o_uv_offset_en;
   logic [8:0][10:0] o_coef;
   int miscompares = 0, total_checks = 0;
   logic [15:0] si [4] = '{WSCCR_IDX_MAIN_FRONT, WSCCR_IDX_OV1_FRONT, WSCCR_IDX_OV2_FRONT,
      WSCCR_IDX_BACK};
   logic [13:0] sv [4] = '{14'h0a00, 14'h0640, 14'h1e00, 14'h2004};
   wire [55:0] so = {o_main_stride, o_ov1_stride, o_ov2_stride, o_back_stride};
   wire [2:0] cv = {o_conv_main, o_conv_ov1, o_conv_ov2};

   wsccr_regs dut (
      .i_clock, .i_nrst, .i_clk_en, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
      .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_vnd, .i_use_back,
      .i_frame_start, .i_line_next, .i_main_base, .i_ov1_base, .i_ov2_base,
      .o_main_line_addr, .o_ov1_line_addr, .o_ov2_line_addr, .o_main_stride, .o_ov1_stride,
      .o_ov2_stride, .o_back_stride, .o_conv_main, .o_conv_ov1, .o_conv_ov2,
      .o_uv_offset_en, .o_coef
   );

   function automatic logic [15:0] ba(logic [15:0] idx);
      return {idx[13:0], 2'h0};
   endfunction
   function automatic logic [15:0] ca(int n);
      return ba(WSCCR_IDX_COEF0 + 16'(n) * WSCCR_IDX_COEF_STEP);
   endfunction

   // Hready is looked at just before the edge that samples it
   task automatic wait_rdy();
      do @(negedge i_clock); while (o_hreadyout !== 1'h1);
      rd_s = o_hrdata;
      @(posedge i_clock);
   endtask
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      i_hsel <= 1'h1;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_haddr <= a;
      wait_rdy();
      i_hsel <= 1'h0;
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      wait_rdy();
   endtask
   task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      `CHK(nm, e, rd_s)
      `CHK("okay", 1'h0, o_hresp)
   endtask

   task automatic t_reset();
      for (int i = 0; i < 4; i++) rchk("stride rst", ba(si[i]), 32'h0);
      rchk("ctl rst", ba(WSCCR_IDX_CTL), 32'h0);
      for (int n = 0; n < 9; n++) rchk("coef rst", ca(n), 32'h0);
      `CHK("conv rst", 3'h0, cv)
   endtask
   task automatic t_strides();
      for (int i = 0; i < 4; i++) begin
         xfer(1'h1, ba(si[i]), 32'hffff_ffff);
         rchk("stride mask", ba(si[i]), 32'h0000_3fff);
         xfer(1'h1, ba(si[i]), {18'h3ffff, sv[i]});
         rchk("stride", ba(si[i]), {18'h0, sv[i]});
      end
      // Misaligned and unmapped writes must leave everything alone
      xfer(1'h1, ba(si[0]) + 16'h1, 32'h0);
      xfer(1'h1, 16'h2204, 32'hffff_ffff);
      rchk("unmapped", 16'h2204, 32'h0);
      // Overlay one stride only written in non-display: no violation flagged
      rchk("status", ba(WSCCR_IDX_STAT), 32'h0000_0001);
      `CHK("stride outs", {sv[0], sv[1], sv[2], sv[3]}, so)
   endtask
   task automatic t_coef();
      logic [10:0] cf;
      for (int n = 0; n < 9; n++) begin
         cf = 11'h4a5 ^ 11'(n * 16'h0093);
         xfer(1'h1, ca(n), {21'h1fffff, cf});
         rchk("coef", ca(n), {21'h0, cf});
         `CHK("coef out", cf, o_coef[n])
      end
   endtask
   task automatic t_ctl();
      logic en;
      logic [1:0] sel;
      for (int c = 0; c < 8; c++) begin
         {sel, en} = 3'(c);
         xfer(1'h1, ba(WSCCR_IDX_CTL), {24'hffffff, ~en, 2'h3, sel, 2'h3, en});
         rchk("ctl", ba(WSCCR_IDX_CTL), {24'h0, ~en, 2'h0, sel, 2'h0, en});
         `CHK("conv", {en & ~|sel, en & ~sel[1], en & ~sel[0]}, cv)
         `CHK("uv", ~en, o_uv_offset_en)
      end
   endtask
   // Frame start wins over a same-cycle line advance
   task automatic t_lines();
      logic [25:0] b [3];
      logic [25:0] e [3];
      b = '{26'h1000000, 26'h0000123, 26'h3ff0000};
      i_main_base <= b[0];
      i_ov1_base <= b[1];
      i_ov2_base <= b[2];
      i_frame_start <= 3'h7;
      i_line_next <= 3'h7;
      @(posedge i_clock);
      i_frame_start <= 3'h0;
      repeat (2) @(posedge i_clock);
      i_use_back <= 3'h7;
      @(posedge i_clock);
      i_line_next <= 3'h0;
      i_use_back <= 3'h0;
      @(negedge i_clock);
      for (int w = 0; w < 3; w++) e[w] = b[w] + 26'(2 * sv[w]) + 26'(sv[3]);
      `CHK("main line", e[0], o_main_line_addr)
      `CHK("ov1 line", e[1], o_ov1_line_addr)
      `CHK("ov2 line", e[2], o_ov2_line_addr)
      // Clock enable low freezes the steppers
      @(posedge i_clock);
      i_clk_en <= 1'h0;
      i_line_next <= 3'h7;
      repeat (2) @(posedge i_clock);
      i_clk_en <= 1'h1;
      i_line_next <= 3'h0;
      @(negedge i_clock);
      `CHK("frozen line", e[0], o_main_line_addr)
      @(posedge i_clock);
   endtask
   // Reset in mid-run clears the strides, main line address, conversion outputs and coefficient 0
   task automatic t_rerst();
      i_nrst <= 1'h0;
      @(posedge i_clock);
      i_nrst <= 1'h1;
      @(negedge i_clock);
      `CHK("stride rerst", 56'h0, so)
      `CHK("line rerst", 26'h0, o_main_line_addr)
      `CHK("conv rerst", 3'h0, cv)
      @(posedge i_clock);
      rchk("coef rerst", ca(0), 32'h0);
   endtask

   task automatic summarize();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      forever #50 i_clock = ~i_clock;
   end
   initial begin
      repeat (6) @(posedge i_clock);
      i_nrst <= 1'h1;
      t_reset();
      t_strides();
      t_coef();
      t_ctl();
      t_lines();
      t_rerst();
      summarize();
   end
   initial begin
      repeat (5000) @(posedge i_clock);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
